// *** hdl/stm_pkg.sv ***
// Notes on behaviour
// [R1] Safety device requests torque off by pulling both channels to 0 V.
// [R2] Enter torque off when both channels drop together or within window.
// [R3] Discrepancy window defaults to one hundred milliseconds.
// [R4] Second channel missing the window raises a discrepancy error.
// [R5] Monitor state machine advances only on the ten-millisecond tick.
// [R6] Levels compared each tick; prolonged inequality raises an error.
// [R7] Brief test pulses on the channels are ignored, not a request.
// [R8] Only the two request channels can trigger torque off.
// [R9] Torque off cuts the gate-driver supply of the power stage.
// [R10] Monitor detects loss of gate-driver supply.
// [R11] Request disables control loop and PWM actuation.
// [R12] Request releases holding brake drive when a brake is configured.
// [R13] Request during active PWM is accepted and flags an error.
// [R14] General acknowledge clears all acknowledgeable safety errors.
// [R15] Safe state reported only after the tick-based evaluation delay.
// [R16] No cross-circuit monitoring of the channel inputs.
// [R17] Standstill position is not monitored in torque off.
// [R18] Switchable 24 V auxiliary sensor supply output.
// [R19] Safety device should switch both channels at the same moment.
// [R20] Leave torque off only when both active and errors acknowledged.
package stm_pkg;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int TICK_MS         = 10;
  localparam int TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int DISC_MS         = 100;
  localparam int DISC_TICKS      = DISC_MS / TICK_MS;
  localparam int PULSE_US        = 1000;
  localparam int PULSE_CYC       = CLK_HZ / 1_000_000 * PULSE_US;
  localparam int UNEQ_TICKS      = 20;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic RST_AUX_ON    = 1'b0;

  typedef enum logic [2:0] {
    STM_RUN,
    STM_ONE_OFF,
    STM_SAFE,
    STM_FAULT
  } stm_state_e;

endpackage : stm_pkg

// *** hdl/stm_ch_if.sv ***
interface stm_ch_if;
  logic raw;
  logic clean;
  modport flt (input raw, output clean);
  modport mon (output raw, input clean);
endinterface : stm_ch_if

// *** hdl/stm_tick.sv ***
module stm_tick
  import stm_pkg::*;
#(
  parameter int PERIOD = TICK_CYC
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  output logic      tick
);
  initial begin
    if (PERIOD < 2) $error("stm_tick: PERIOD too small");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } stm_tick_s;

  stm_tick_s s_q, s_d;

  // -------------------------------------------------------------------
  // Free-running divider producing one-cycle tick
  // -------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(PERIOD - 1)) begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick & ce;
endmodule : stm_tick

// *** hdl/stm_pulse_flt.sv ***
module stm_pulse_flt
  import stm_pkg::*;
#(
  parameter int HOLD = PULSE_CYC
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  stm_ch_if.flt     ch
);
  initial begin
    if (HOLD < 1) $error("stm_pulse_flt: HOLD too small");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        clean;
  } stm_flt_s;

  stm_flt_s s_q, s_d;

  // -------------------------------------------------------------------
  // Low must persist HOLD cycles; return to high passes at once
  // -------------------------------------------------------------------
  // Trade-off: a genuine request is seen HOLD cycles late, far below tick
  always_comb begin
    s_d = s_q;
    if (ch.raw) begin
      s_d.cnt   = 32'h0;
      s_d.clean = 1'b1;
    end else if (s_q.cnt >= 32'(HOLD - 1)) begin
      s_d.clean = 1'b0; // see [R7]
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '{cnt: 32'h0, clean: 1'b1};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ch.clean = s_q.clean;
endmodule : stm_pulse_flt

// *** hdl/stm_monitor.sv ***
module stm_monitor
  import stm_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYC,
  parameter int PULSE_HOLD  = PULSE_CYC,
  parameter int DISC_LIMIT  = DISC_TICKS,
  parameter int UNEQ_LIMIT  = UNEQ_TICKS
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic torque_off_request_a,
  input  wire logic torque_off_request_b,
  input  wire logic gate_supply_ok,
  input  wire logic pwm_active,
  input  wire logic brake_configured,
  input  wire logic brake_request,
  input  wire logic error_ack,
  input  wire logic aux_enable,
  output logic      gate_supply_en,
  output logic      control_enable,
  output logic      pwm_enable,
  output logic      brake_drive,
  output logic      safe_torque_off,
  output logic      supply_lost,
  output logic      err_discrepancy,
  output logic      err_unequal,
  output logic      err_pwm_active,
  output logic      aux_sensor_supply_out
);
  initial begin
    if (DISC_LIMIT < 1 || DISC_LIMIT > 255)
      $error("stm_monitor: DISC_LIMIT out of range");
    if (UNEQ_LIMIT < 1 || UNEQ_LIMIT > 255)
      $error("stm_monitor: UNEQ_LIMIT out of range");
  end

  // -------------------------------------------------------------------
  // Channel filters and evaluation tick
  // -------------------------------------------------------------------
  // Only these two channels feed the state machine; no other input may
  // request torque off, so fieldbus or I/O stay out of this path
  stm_ch_if ch_a ();
  stm_ch_if ch_b ();

  assign ch_a.raw = torque_off_request_a; // see [R8]
  assign ch_b.raw = torque_off_request_b; // see [R8]

  logic tick;

  stm_tick #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .tick (tick)
  );

  stm_pulse_flt #(
    .HOLD (PULSE_HOLD)
  ) u_flt_a (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .ch   (ch_a.flt)
  );

  stm_pulse_flt #(
    .HOLD (PULSE_HOLD)
  ) u_flt_b (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .ch   (ch_b.flt)
  );

  // Channel inactive means voltage removed (low level)
  logic off_a;
  logic off_b;
  logic any_off;
  logic both_off;
  logic both_on;

  assign off_a    = ~ch_a.clean; // see [R1]
  assign off_b    = ~ch_b.clean; // see [R1]
  assign any_off  = off_a | off_b;
  assign both_off = off_a & off_b;
  assign both_on  = ~any_off;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    stm_state_e  st;
    logic [7:0]  disc_cnt;
    logic [7:0]  uneq_cnt;
    logic        err_disc;
    logic        err_uneq;
    logic        err_pwm;
    logic        safe_off;
    logic        ctl_en;
    logic        pwm_en;
    logic        brake;
    logic        gate_en;
    logic        lost;
    logic        aux;
  } stm_mon_s;

  stm_mon_s s_q, s_d;

  logic any_err;
  assign any_err = s_q.err_disc | s_q.err_uneq | s_q.err_pwm;

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Acknowledge clears all safety errors together; any error raised
    // later in this same cycle overrides the clear, so the set wins
    if (error_ack) begin // see [R14]
      s_d.err_disc = 1'b0;
      s_d.err_uneq = 1'b0;
      s_d.err_pwm  = 1'b0;
    end

    // Gate-driver supply follows the filtered channels directly, so the
    // power stage is off long before the tick-based state reports it
    s_d.gate_en = both_on; // see [R9]

    // Loss of driver supply seen on the sense input
    s_d.lost = ~gate_supply_ok; // see [R10]

    // Aux supply is a plain switch for external sensors
    s_d.aux = aux_enable; // see [R18]

    // Request seen at once: drop control, PWM and brake drive
    if (any_off) begin
      s_d.ctl_en = 1'b0; // see [R11]
      s_d.pwm_en = 1'b0; // see [R11]
    end
    if (any_off || s_q.st == STM_SAFE || s_q.st == STM_FAULT) begin
      s_d.brake = 1'b0; // see [R12]
    end else begin
      s_d.brake = brake_configured & brake_request;
    end

    // Request while PWM still switching: accepted, but flagged
    if (any_off && pwm_active && s_q.pwm_en) begin
      s_d.err_pwm = 1'b1; // see [R13]
    end

    // Wiring faults between channels are not checked here; the external
    // safety relay must provide cross-circuit detection if needed
    // see [R16]

    // The state machine moves only on the evaluation tick
    if (tick) begin // see [R5]
      // Unequal levels counted on every tick
      if (off_a != off_b) begin // see [R6]
        if (s_q.uneq_cnt >= 8'(UNEQ_LIMIT - 1)) begin
          s_d.err_uneq = 1'b1; // see [R6]
        end else begin
          s_d.uneq_cnt = s_q.uneq_cnt + 8'h01;
        end
      end else begin
        s_d.uneq_cnt = 8'h00;
      end

      case (s_q.st)
        STM_RUN: begin
          if (both_off) begin
            s_d.st       = STM_SAFE; // see [R2]
            s_d.safe_off = 1'b1; // see [R15]
          end else if (any_off) begin
            s_d.st       = STM_ONE_OFF;
            s_d.disc_cnt = 8'h01;
          end
        end
        STM_ONE_OFF: begin
          if (both_off) begin
            s_d.st       = STM_SAFE; // see [R2]
            s_d.safe_off = 1'b1; // see [R15]
          end else if (both_on) begin
            s_d.st = STM_RUN;
          end else if (s_q.disc_cnt >= 8'(DISC_LIMIT)) begin
            // Window elapsed with only one channel off, see [R3]
            s_d.st       = STM_FAULT;
            s_d.err_disc = 1'b1; // see [R4]
          end else begin
            s_d.disc_cnt = s_q.disc_cnt + 8'h01;
          end
        end
        STM_SAFE: begin
          // No standstill supervision in this state, see [R17]
          if (both_on && !any_err) begin
            s_d.st       = STM_RUN; // see [R20]
            s_d.safe_off = 1'b0;
            s_d.ctl_en   = 1'b1;
            s_d.pwm_en   = 1'b1;
          end
        end
        STM_FAULT: begin
          if (both_off) begin
            s_d.st       = STM_SAFE;
            s_d.safe_off = 1'b1;
          end else if (both_on && !any_err) begin
            s_d.st     = STM_RUN; // see [R20]
            s_d.ctl_en = 1'b1;
            s_d.pwm_en = 1'b1;
          end
        end
        default: begin
          s_d.st       = STM_SAFE;
          s_d.safe_off = 1'b1;
        end
      endcase
      if (s_d.st != STM_ONE_OFF) begin
        s_d.disc_cnt = 8'h00;
      end
      if (s_d.st == STM_RUN) begin
        s_d.ctl_en = both_on;
        s_d.pwm_en = both_on;
      end
    end

  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  // Reset starts in the safe state: motion needs both channels active
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '{st: STM_SAFE, disc_cnt: 8'h00, uneq_cnt: 8'h00,
               err_disc: 1'b0, err_uneq: 1'b0, err_pwm: 1'b0,
               safe_off: 1'b1, ctl_en: 1'b0, pwm_en: 1'b0, brake: 1'b0,
               gate_en: 1'b0, lost: 1'b0, aux: RST_AUX_ON};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign gate_supply_en        = s_q.gate_en;
  assign control_enable        = s_q.ctl_en;
  assign pwm_enable            = s_q.pwm_en;
  assign brake_drive           = s_q.brake;
  assign safe_torque_off       = s_q.safe_off;
  assign supply_lost           = s_q.lost;
  assign err_discrepancy       = s_q.err_disc;
  assign err_unequal           = s_q.err_uneq;
  assign err_pwm_active        = s_q.err_pwm;
  assign aux_sensor_supply_out = s_q.aux;
endmodule : stm_monitor

// *** bench/stm_monitor_assertions.sv ***
module stm_monitor_assertions #(
  parameter int TICK_PERIOD = 20,
  parameter int PULSE_HOLD  = 3,
  parameter int DISC_LIMIT  = 10,
  parameter int UNEQ_LIMIT  = 20
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic torque_off_request_a,
  input wire logic torque_off_request_b,
  input wire logic gate_supply_ok,
  input wire logic pwm_active,
  input wire logic brake_configured,
  input wire logic brake_request,
  input wire logic error_ack,
  input wire logic aux_enable,
  input wire logic gate_supply_en,
  input wire logic control_enable,
  input wire logic pwm_enable,
  input wire logic brake_drive,
  input wire logic safe_torque_off,
  input wire logic supply_lost,
  input wire logic err_discrepancy,
  input wire logic err_unequal,
  input wire logic err_pwm_active,
  input wire logic aux_sensor_supply_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Run length of raw channel disagreement
  // -------------------------------------------------------------
  int unsigned run_q;
  // Raw levels, so a filter that lags cannot hide a slow error
  always_ff @(posedge mclk) begin
    if (srst || torque_off_request_a == torque_off_request_b) begin
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  AST_PULSE_IGNORED: assert property (
    $fell(gate_supply_en) |->
      !$past(torque_off_request_a, 3) && !$past(torque_off_request_a, 2)
      || !$past(torque_off_request_b, 3) && !$past(torque_off_request_b, 2))
    else $error("driver supply cut by a short pulse");
  AST_GATE_BEFORE_PWM: assert property (
    pwm_enable |-> gate_supply_en)
    else $error("pwm allowed without driver supply");
  AST_SAFE_QUIET: assert property (
    safe_torque_off |-> !pwm_enable && !control_enable && !brake_drive)
    else $error("drive active in safe state");
  AST_SAFE_CAUSE: assert property (
    $rose(safe_torque_off) |-> err_discrepancy
      || !torque_off_request_a && !torque_off_request_b)
    else $error("safe state without both channels off");
  AST_DISC_WINDOW: assert property (
    $rose(err_discrepancy) |-> run_q >= (DISC_LIMIT - 1) * TICK_PERIOD)
    else $error("discrepancy flagged inside the window");
  AST_UNEQ_BOUND: assert property (
    run_q == (UNEQ_LIMIT + 2) * TICK_PERIOD |-> err_unequal)
    else $error("long inequality not flagged");
  AST_PWM_ERR: assert property (
    $rose(err_pwm_active) |-> $past(pwm_enable) && $past(pwm_active))
    else $error("pwm error without active pwm");
  AST_ACK_CLEARS: assert property (
    error_ack && !pwm_active && torque_off_request_a && torque_off_request_b
      |=> !err_discrepancy && !err_unequal && !err_pwm_active)
    else $error("acknowledge left an error set");
  AST_RUN_CLEAN: assert property (
    $rose(control_enable) |-> torque_off_request_a && torque_off_request_b
      && !err_discrepancy && !err_unequal && !err_pwm_active)
    else $error("run resumed with error or channel off");
  COV_SAFE: cover property ($rose(safe_torque_off));
  COV_DISC: cover property ($rose(err_discrepancy));
  COV_PWM: cover property ($rose(err_pwm_active));
endmodule : stm_monitor_assertions

bind stm_monitor stm_monitor_assertions #(
  .TICK_PERIOD(TICK_PERIOD),
  .PULSE_HOLD (PULSE_HOLD),
  .DISC_LIMIT (DISC_LIMIT),
  .UNEQ_LIMIT (UNEQ_LIMIT)
) u_chk (.*);

// *** bench/stm_relay.sv ***
module stm_relay (
  input  wire logic mclk,
  input  wire logic off_req,
  input  int        skew,
  input  wire logic pulse,
  output logic      ch_a,
  output logic      ch_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    ch_a = 1'b1;
    ch_b = 1'b1;
    cnt = 0;
  end
  // A drops at once, B trails by skew cycles; huge skew never drops
  always @(posedge mclk) begin
    if (!off_req) begin
      cnt <= 0;
      ch_a <= !pulse;
      ch_b <= !pulse;
    end else begin
      ch_a <= 1'b0;
      if (cnt >= skew) begin
        ch_b <= 1'b0;
      end
      cnt <= cnt + 1;
    end
  end
endmodule : stm_relay

// *** bench/tb_stm_monitor.sv ***
module tb_stm_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Short counts keep the run brief
  // -------------------------------------------------------------
  localparam int P  = 20;
  localparam int H  = 3;
  localparam int DL = 10;
  localparam int UL = 20;
  logic mclk, srst, ce, gate_supply_ok, pwm_active, brake_configured;
  logic brake_request, error_ack, aux_enable, off_req, pulse;
  logic torque_off_request_a, torque_off_request_b, gate_supply_en;
  logic control_enable, pwm_enable, brake_drive, safe_torque_off;
  logic supply_lost, err_discrepancy, err_unequal, err_pwm_active;
  logic aux_sensor_supply_out;
  int   num_errors, tests_run, skew, seed;
  stm_monitor #(.TICK_PERIOD(P), .PULSE_HOLD(H), .DISC_LIMIT(DL),
    .UNEQ_LIMIT(UL)) uut (.*);
  stm_relay u_relay (.mclk(mclk), .off_req(off_req), .skew(skew),
    .pulse(pulse), .ch_a(torque_off_request_a),
    .ch_b(torque_off_request_b));
  always #2.5 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Drive state as seen at the ports
  task automatic st(input logic run);
    chk(control_enable, run);
    chk(pwm_enable, run);
    chk(safe_torque_off, !run);
  endtask : st
  task automatic ack;
    error_ack = 1'b1;
    cyc(1);
    error_ack = 1'b0;
  endtask : ack
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Whole sequence needs about 50 ticks
  initial begin
    #(200 * P * 5);
    num_errors++;
    wrap_up;
  end
  initial begin
    mclk = 0;
    srst = 1;
    ce = 1;
    {gate_supply_ok, brake_configured, brake_request} = 3'h7;
    {pwm_active, error_ack, aux_enable, off_req, pulse} = 5'h00;
    skew = 0;
    seed = 32'hB21990AF;
    num_errors = 0;
    tests_run = 0;
    cyc(5);
    st(1'b0);
    srst = 0;
    cyc(3 * P);
    st(1'b1);
    chk(brake_drive, 1'b1);
    // Test pulse shorter than the filter hold
    pulse = 1;
    cyc(H - 1);
    pulse = 0;
    cyc(2 * P);
    st(1'b1);
    // Both off together while pwm switches
    pwm_active = 1;
    off_req = 1;
    cyc(H + 5);
    chk(gate_supply_en, 1'b0);
    chk(pwm_enable, 1'b0);
    chk(brake_drive, 1'b0);
    chk(err_pwm_active, 1'b1);
    cyc(2 * P);
    chk(safe_torque_off, 1'b1);
    pwm_active = 0;
    off_req = 0;
    cyc(3 * P);
    st(1'b0);
    ack;
    cyc(2 * P);
    st(1'b1);
    // B trails inside the window
    skew = 3 * P;
    off_req = 1;
    cyc(6 * P);
    chk(safe_torque_off, 1'b1);
    chk(err_discrepancy, 1'b0);
    off_req = 0;
    cyc(3 * P);
    st(1'b1);
    // B never follows
    skew = 1000000;
    off_req = 1;
    cyc((DL - 2) * P);
    chk(err_discrepancy, 1'b0);
    cyc(5 * P);
    chk(err_discrepancy, 1'b1);
    chk(err_unequal, 1'b0);
    cyc((UL - DL) * P);
    chk(err_unequal, 1'b1);
    off_req = 0;
    cyc(2 * P);
    // Fault is an error state, not the reported safe state
    chk(control_enable, 1'b0);
    chk(pwm_enable, 1'b0);
    chk(safe_torque_off, 1'b0);
    chk(gate_supply_en, 1'b1);
    chk(err_discrepancy, 1'b1);
    ack;
    cyc(2 * P);
    st(1'b1);
    chk(err_unequal, 1'b0);
    chk(err_discrepancy, 1'b0);
    // Random side inputs never stop the drive
    repeat (24) begin
      aux_enable = 1'($random(seed));
      gate_supply_ok = 1'($random(seed));
      brake_request = 1'($random(seed));
      brake_configured = 1'($random(seed));
      cyc(1);
      chk(aux_sensor_supply_out, aux_enable);
      chk(supply_lost, !gate_supply_ok);
      chk(brake_drive, brake_configured & brake_request);
    end
    st(1'b1);
    // Clock enable low freezes the registered outputs
    ce = 0;
    aux_enable = !aux_enable;
    cyc(3);
    chk(aux_sensor_supply_out, !aux_enable);
    ce = 1;
    cyc(1);
    chk(aux_sensor_supply_out, aux_enable);
    wrap_up;
  end
endmodule : tb_stm_monitor
